// >>> src/amp_fault_pkg.sv
// Functional notes
// - Latching faults and clock error pull fault pin low
// - Fault pin only drives low or releases
// - Latching fault holds until toggle plus timeout
// - Non-latching errors other than clock error never assert fault
// - Clock error asserts fault, recovers automatically
// - Overvoltage is non-latching, no fault pin
// - Undervoltage is non-latching, no fault pin
// - Bad ratio, rate or stopped clock flags error
// - Overcurrent latches; timeout and toggle clear it
// - DC offset latches; timeout and toggle clear it
// - Overtemp latches; also needs hysteresis cleared
// - Duty above 60% same polarity 420 ms trips
// - Hardware mode uses defaults plus static pins
// - All static pins low: stereo bridge, 768 kHz
// - Persisting latched error refaults after shutdown release
// - Shutdown low stops amplifier, high runs it
package amp_fault_pkg;
  // Clock rate in hertz (25 MHz)
  localparam int unsigned CLK_HZ           = 25_000_000;
  // DC detect persistence time in milliseconds
  localparam int unsigned DC_PERSIST_MS    = 420;
  // Default fault recovery time in milliseconds
  localparam int unsigned RECOVERY_MS      = 100;
  localparam int unsigned MS_PER_S         = 1000;
  // Cycle counts derived from rate
  localparam int unsigned DC_PERSIST_CYC   =
    DC_PERSIST_MS * (CLK_HZ / MS_PER_S);
  localparam int unsigned RECOVERY_CYC     =
    RECOVERY_MS * (CLK_HZ / MS_PER_S);
  // Duty threshold in percent
  localparam int unsigned DUTY_LIMIT_PCT   = 60;
  // Duty measurement window width and length
  localparam int unsigned DUTY_W           = 8;
  localparam logic [7:0]  DUTY_WINDOW      = 8'h64;
  // Counter width for long timers
  localparam int unsigned CNT_W            = 24;
  // Register bus offsets
  localparam logic [7:0]  OFS_STATUS       = 8'h00;
  localparam logic [7:0]  OFS_MASK         = 8'h04;
  localparam logic [7:0]  OFS_CONTROL      = 8'h08;
  localparam logic [7:0]  OFS_STATE        = 8'h0C;
  // Status bit positions (also mask positions)
  localparam int unsigned ST_OVE           = 0;
  localparam int unsigned ST_UVE           = 1;
  localparam int unsigned ST_CLOCKING_ERROR          = 2;
  localparam int unsigned ST_OCE           = 3;
  localparam int unsigned ST_DCE           = 4;
  localparam int unsigned ST_OTE           = 5;
  localparam int unsigned NUM_ERR          = 6;
  // Control bit: shutdown bit, active low
  localparam int unsigned CTL_SD_N         = 0;
  localparam logic [31:0] CTL_RESET        = 32'h0000_0001;
  localparam logic [5:0]  MASK_RESET       = 6'h00;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // Static configuration defaults
  localparam logic        BRIDGE_STEREO    = 1'h0;
  localparam logic        SWF_768K         = 1'h0;
  // Recovery sequencer states
  typedef enum logic [1:0] {
    RS_RUN, RS_FAULT, RS_WAIT_HIGH, RS_TIMEOUT
  } rec_state_t;
endpackage

// >>> src/dc_detect.sv
`timescale 1ns/10ps
// Measures output duty cycle per window and flags persistent DC
module dc_detect #(
  parameter int unsigned PERSIST_CYC = amp_fault_pkg::DC_PERSIST_CYC
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic pwm_diff_i,   // Differential sign, 1 = positive
  output logic      dc_error_o    // High while DC detected
);
  logic [7:0] win_q, win_d;       // Window position
  logic [7:0] hi_q, hi_d;         // Positive cycles in window
  logic [1:0] pol_q, pol_d;       // Last window polarity, 0 none
  logic [amp_fault_pkg::CNT_W-1:0] cnt_q, cnt_d; // Persistence
  logic       err_q, err_d;
  logic [1:0] pol_now;
  logic [7:0] hi_sum;             // Positive cycles including this one

  // Compare duty against limit in percent
  function automatic logic over_limit(input logic [7:0] n);
    over_limit = 32'(n) * 100 >
      amp_fault_pkg::DUTY_LIMIT_PCT * 32'(amp_fault_pkg::DUTY_WINDOW);
  endfunction

  // Next state of window and persistence counter
  always_comb begin
    hi_sum = hi_q + {7'h00, pwm_diff_i};
    win_d = win_q + 8'h01;
    hi_d  = hi_sum;
    pol_d = pol_q;
    cnt_d = cnt_q;
    err_d = err_q;
    pol_now = 2'h0;
    if (win_q == amp_fault_pkg::DUTY_WINDOW - 8'h01) begin
      win_d = 8'h00;
      hi_d  = 8'h00;
      // Classify window polarity from the full window count
      if (over_limit(hi_sum)) begin
        pol_now = 2'h1;
      end else if (over_limit(amp_fault_pkg::DUTY_WINDOW - hi_sum)) begin
        pol_now = 2'h2;
      end
      pol_d = pol_now;
      // Restart whenever condition or polarity is lost
      if (pol_now == 2'h0 || pol_now != pol_q) begin
        cnt_d = '0;
        err_d = 1'b0;
      end else if (cnt_q >= PERSIST_CYC) begin
        err_d = 1'b1;
      end
    end
    if (pol_q != 2'h0 && cnt_q < PERSIST_CYC) begin
      cnt_d = cnt_d + 1'b1;
    end
  end

  // Register state
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      win_q <= '0;
      hi_q  <= '0;
      pol_q <= '0;
      cnt_q <= '0;
      err_q <= 1'b0;
    end else begin
      win_q <= win_d;
      hi_q  <= hi_d;
      pol_q <= pol_d;
      cnt_q <= cnt_d;
      err_q <= err_d;
    end
  end
  assign dc_error_o = err_q;
endmodule

// >>> src/clock_check.sv
`timescale 1ns/10ps
// Combines clock monitor indications into one clocking error
module clock_check (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic bad_ratio_i,     // Unsupported clock ratio
  input  wire logic bad_rate_i,      // Unsupported clock rate
  input  wire logic clk_stopped_i,   // A serial clock stopped
  output logic      clocking_error_o
);
  logic err_q, err_d;
  // Any condition flags the error
  always_comb begin
    err_d = bad_ratio_i | bad_rate_i | clk_stopped_i;
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end
  assign clocking_error_o = err_q;
endmodule

// >>> src/amp_fault_ctrl.sv
`timescale 1ns/10ps
// Amplifier fault classification and recovery control
module amp_fault_ctrl #(
  parameter int unsigned RECOVERY_CYC = amp_fault_pkg::RECOVERY_CYC,
  parameter int unsigned DC_CYC       = amp_fault_pkg::DC_PERSIST_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // Error indications from analog monitors
  input  wire logic        supply_overvoltage_i,
  input  wire logic        supply_undervoltage_i,
  input  wire logic        output_overcurrent_i,
  input  wire logic        die_overtemp_i,
  input  wire logic        overtemp_hysteresis_i, // High while still hot
  input  wire logic        pwm_diff_l_i,
  input  wire logic        pwm_diff_r_i,
  input  wire logic        bad_ratio_i,
  input  wire logic        bad_rate_i,
  input  wire logic        clk_stopped_i,
  // Shutdown pin and static configuration
  input  wire logic        amp_shutdown_n_i,
  input  wire logic        hw_mode_i,
  input  wire logic        parallel_bridge_pin_i,
  input  wire logic        freq_sel_pin_i,
  // Open-drain fault pin
  input  wire logic        amp_fault_n_i,
  output logic             amp_fault_n_o,
  output logic             amp_fault_n_oe_o,
  // Amplifier control
  output logic             amp_play_o,
  output logic             parallel_bridge_mode_o,
  output logic             freq_sel_o,
  output logic             irq_o,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int unsigned N = amp_fault_pkg::NUM_ERR;

  logic dc_l, dc_r, clk_err;        // Submodule results
  logic [N-1:0] raw;                // Live error indications
  logic [N-1:0] status_q, status_d; // Sticky status
  logic [N-1:0] mask_q, mask_d;     // Interrupt mask
  logic         sdbit_q, sdbit_d;   // Software shutdown bit
  logic         sd_prev_q;          // Previous combined shutdown
  logic         sd_comb;            // Pin and bit combined
  amp_fault_pkg::rec_state_t rs_q, rs_d;
  logic [amp_fault_pkg::CNT_W-1:0] tmo_q, tmo_d;
  logic         flt_n_q, flt_n_d;   // Fault pin pull request, low
  logic         play_q, play_d;
  logic         irq_q, irq_d;
  logic         pb_q, pb_d, fs_q, fs_d;
  logic         latch_now;          // A latching error active
  // Bus state
  logic         aw_q, aw_d, w_q, w_d, bv_q, bv_d;
  logic [7:0]   awa_q, awa_d;
  logic [31:0]  wd_q, wd_d;
  logic [3:0]   ws_q, ws_d;
  logic [1:0]   br_q, br_d;
  logic         rv_q, rv_d;
  logic [31:0]  rd_q, rd_d;
  logic [1:0]   rr_q, rr_d;
  logic         wr_go;
  logic         w1c_hit;
  logic         pin_free;           // Recovery time over, pin may let go
  logic         pull_q, pull_d;     // Registered fault pin enable
  logic         awrdy_q, awrdy_d;   // Registered bus ready flags
  logic         wrdy_q, wrdy_d;
  logic         arrdy_q, arrdy_d;

  // DC detectors, one per channel
  dc_detect #(.PERSIST_CYC(DC_CYC)) u_dc_l (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .pwm_diff_i (pwm_diff_l_i),
    .dc_error_o (dc_l)
  );
  dc_detect #(.PERSIST_CYC(DC_CYC)) u_dc_r (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .pwm_diff_i (pwm_diff_r_i),
    .dc_error_o (dc_r)
  );
  clock_check u_clk (
    .mclk_i           (mclk_i),
    .sys_rst_i        (sys_rst_i),
    .bad_ratio_i      (bad_ratio_i),
    .bad_rate_i       (bad_rate_i),
    .clk_stopped_i    (clk_stopped_i),
    .clocking_error_o (clk_err)
  );

  // Collect error indications
  always_comb begin
    raw = '0;
    raw[amp_fault_pkg::ST_OVE]  = supply_overvoltage_i;
    raw[amp_fault_pkg::ST_UVE]  = supply_undervoltage_i;
    raw[amp_fault_pkg::ST_CLOCKING_ERROR] = clk_err;
    raw[amp_fault_pkg::ST_OCE]  = output_overcurrent_i;
    raw[amp_fault_pkg::ST_DCE]  = dc_l | dc_r;
    raw[amp_fault_pkg::ST_OTE]  = die_overtemp_i;
    latch_now = raw[amp_fault_pkg::ST_OCE] | raw[amp_fault_pkg::ST_DCE]
              | raw[amp_fault_pkg::ST_OTE];
    sd_comb = amp_shutdown_n_i & sdbit_q;
  end

  // Recovery sequencer and fault pin
  always_comb begin
    rs_d   = rs_q;
    tmo_d  = tmo_q;
    case (rs_q)
      amp_fault_pkg::RS_RUN: begin
        if (latch_now && sd_comb) begin
          rs_d  = amp_fault_pkg::RS_FAULT;
          tmo_d = '0;
        end
      end
      amp_fault_pkg::RS_FAULT: begin
        // Timeout runs from the fault; shutdown must go low
        if (tmo_q < RECOVERY_CYC) begin
          tmo_d = tmo_q + 1'b1;
        end
        if (!sd_comb) begin
          rs_d = amp_fault_pkg::RS_WAIT_HIGH;
        end
      end
      amp_fault_pkg::RS_WAIT_HIGH: begin
        if (tmo_q < RECOVERY_CYC) begin
          tmo_d = tmo_q + 1'b1;
        end
        if (sd_comb && !sd_prev_q) begin
          rs_d = amp_fault_pkg::RS_TIMEOUT;
        end
      end
      amp_fault_pkg::RS_TIMEOUT: begin
        if (tmo_q < RECOVERY_CYC) begin
          tmo_d = tmo_q + 1'b1;
        end
        if (!sd_comb) begin
          rs_d = amp_fault_pkg::RS_WAIT_HIGH;
        end else if (tmo_q >= RECOVERY_CYC) begin
          // Hot die must also drop under hysteresis
          if (latch_now || overtemp_hysteresis_i) begin
            rs_d  = amp_fault_pkg::RS_FAULT;
            tmo_d = '0;
          end else begin
            rs_d = amp_fault_pkg::RS_RUN;
          end
        end
      end
      default: rs_d = amp_fault_pkg::RS_RUN;
    endcase
    // Once the recovery time is over the pin lets go while shutdown is
    // low, so a host that loops it back to shutdown can restart alone
    pin_free = (tmo_q >= RECOVERY_CYC)
               && ((rs_q == amp_fault_pkg::RS_WAIT_HIGH)
                   || (rs_q == amp_fault_pkg::RS_TIMEOUT && !latch_now
                       && !overtemp_hysteresis_i));
    // Pin low for latched state or clock error only
    flt_n_d = !(((rs_q != amp_fault_pkg::RS_RUN) && !pin_free)
                || clk_err);
    pull_d  = !flt_n_d;
    play_d  = (rs_q == amp_fault_pkg::RS_RUN) && sd_comb && !latch_now
              && (raw == '0);
    // Static configuration, all low gives defaults
    pb_d = hw_mode_i ? parallel_bridge_pin_i : amp_fault_pkg::BRIDGE_STEREO;
    fs_d = hw_mode_i ? freq_sel_pin_i : amp_fault_pkg::SWF_768K;
  end

  // Bus write acceptance and status register
  always_comb begin
    aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; ws_d = ws_q;
    bv_d = bv_q; br_d = br_q;
    rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    mask_d  = mask_q;
    sdbit_d = sdbit_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1; awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1; wd_d = s_axi_wdata; ws_d = s_axi_wstrb;
    end
    wr_go   = aw_q && w_q && !bv_q;
    w1c_hit = wr_go && awa_q == amp_fault_pkg::OFS_STATUS && ws_q[0];
    if (wr_go) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1; br_d = amp_fault_pkg::RESP_OKAY;
      case (awa_q)
        amp_fault_pkg::OFS_STATUS: ;
        amp_fault_pkg::OFS_MASK: if (ws_q[0]) mask_d = wd_q[N-1:0];
        amp_fault_pkg::OFS_CONTROL:
          if (ws_q[0]) sdbit_d = wd_q[amp_fault_pkg::CTL_SD_N];
        default: br_d = amp_fault_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    // Sticky status: set wins over write-one clear
    status_d = (w1c_hit ? status_q & ~wd_q[N-1:0] : status_q) | raw;
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1; rr_d = amp_fault_pkg::RESP_OKAY;
      case (s_axi_araddr)
        amp_fault_pkg::OFS_STATUS:  rd_d = 32'(status_q);
        amp_fault_pkg::OFS_MASK:    rd_d = 32'(mask_q);
        amp_fault_pkg::OFS_CONTROL: rd_d = 32'(sdbit_q);
        amp_fault_pkg::OFS_STATE:   rd_d = 32'({play_q, !flt_n_q, rs_q});
        default: begin
          rd_d = '0; rr_d = amp_fault_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    irq_d = |(status_d & mask_d);
    // Ready flags follow the next holding state
    awrdy_d = !aw_d;
    wrdy_d  = !w_d;
    arrdy_d = !rv_d;
  end

  // Register all state
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rs_q <= amp_fault_pkg::RS_RUN; tmo_q <= '0;
      flt_n_q <= 1'b1; play_q <= 1'b0; irq_q <= 1'b0;
      pull_q <= 1'b0; awrdy_q <= 1'b1;
      wrdy_q <= 1'b1; arrdy_q <= 1'b1;
      pb_q <= 1'b0; fs_q <= 1'b0; sd_prev_q <= 1'b0;
      status_q <= '0; mask_q <= amp_fault_pkg::MASK_RESET;
      sdbit_q <= amp_fault_pkg::CTL_RESET[amp_fault_pkg::CTL_SD_N];
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= '0; wd_q <= '0; ws_q <= '0;
      bv_q <= 1'b0; br_q <= '0; rv_q <= 1'b0; rd_q <= '0; rr_q <= '0;
    end else begin
      rs_q <= rs_d; tmo_q <= tmo_d;
      flt_n_q <= flt_n_d; play_q <= play_d; irq_q <= irq_d;
      pull_q <= pull_d; awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d; arrdy_q <= arrdy_d;
      pb_q <= pb_d; fs_q <= fs_d; sd_prev_q <= sd_comb;
      status_q <= status_d; mask_q <= mask_d; sdbit_q <= sdbit_d;
      aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
    end
  end

  // Open drain: value always low, enable pulls
  assign amp_fault_n_o    = 1'b0;
  assign amp_fault_n_oe_o = pull_q;
  assign amp_play_o       = play_q;
  assign parallel_bridge_mode_o = pb_q;
  assign freq_sel_o       = fs_q;
  assign irq_o            = irq_q;
  assign s_axi_awready    = awrdy_q;
  assign s_axi_wready     = wrdy_q;
  assign s_axi_bvalid     = bv_q;
  assign s_axi_bresp      = br_q;
  assign s_axi_arready    = arrdy_q;
  assign s_axi_rvalid     = rv_q;
  assign s_axi_rdata      = rd_q;
  assign s_axi_rresp      = rr_q;

  AST_CLK_FAULT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_err |=> amp_fault_n_oe_o)
    else $error("Clock error did not pull fault");
  AST_NONLATCH: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rs_q == amp_fault_pkg::RS_RUN && !clk_err) |=> !amp_fault_n_oe_o)
    else $error("Fault pulled without cause");
  AST_LATCH_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rs_q == amp_fault_pkg::RS_FAULT) |=> amp_fault_n_oe_o)
    else $error("Latched fault released early");
  AST_NEVER_HIGH: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    amp_fault_n_o == 1'b0)
    else $error("Fault pin driven high");
  AST_DETECT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rs_q == amp_fault_pkg::RS_RUN && latch_now && sd_comb)
      |=> rs_q == amp_fault_pkg::RS_FAULT ##1 amp_fault_n_oe_o)
    else $error("Latching error not detected");
  AST_TIMEOUT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ($past(rs_q) == amp_fault_pkg::RS_TIMEOUT &&
     rs_q == amp_fault_pkg::RS_RUN) |-> tmo_q >= RECOVERY_CYC)
    else $error("Recovered before timeout");
  AST_HOT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rs_q == amp_fault_pkg::RS_TIMEOUT && overtemp_hysteresis_i)
      |=> rs_q != amp_fault_pkg::RS_RUN)
    else $error("Recovered while hot");
  AST_DEFAULT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !hw_mode_i |=> !parallel_bridge_mode_o && !freq_sel_o)
    else $error("Default configuration wrong");
endmodule

// >>> testbench/fault_host_model.sv
`timescale 1ns/10ps
// Host model: watches the fault net and drives the shutdown pin
module fault_host_model (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       fault_net_i, // Resolved fault net level
  input  wire logic       loop_en_i,   // Feed fault net to shutdown
  input  wire logic       sd_req_i,    // Level asked by the bench
  input  wire logic [3:0] lag_i,       // Reaction delay in cycles
  output logic            amp_shutdown_n_o
);
  logic [3:0] lag_q; // Cycles left before following
  logic       want;  // Level the host wants on the pin
  // Loop-back or bench-commanded shutdown level
  always_comb want = loop_en_i ? fault_net_i : sd_req_i;
  // Follow the wanted level once the reaction delay has run out
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      amp_shutdown_n_o <= 1'b1;
      lag_q            <= 4'h0;
    end else if (want == amp_shutdown_n_o || lag_q == 4'h0) begin
      amp_shutdown_n_o <= want;
      lag_q            <= lag_i;
    end else begin
      lag_q <= lag_q - 4'h1;
    end
  end
endmodule

// >>> testbench/amp_fault_ctrl_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the amplifier fault controller
module amp_fault_ctrl_tb;
  localparam int          REC  = 50;  // Shortened recovery count
  localparam int          DCC  = 300; // Shortened DC persistence count
  localparam logic [7:0]  A_ST = amp_fault_pkg::OFS_STATUS;
  localparam logic [7:0]  A_MK = amp_fault_pkg::OFS_MASK;
  localparam logic [7:0]  A_CT = amp_fault_pkg::OFS_CONTROL;
  localparam logic [31:0] ALL  = 32'h0000_003F; // Every status bit
  logic        mclk_i  = 1'b0; // Core clock
  logic        rst     = 1'b1; // Synchronous reset
  logic [6:0]  err     = '0;   // ov,uv,ratio,rate,stop,oc,ot
  logic        hyst    = 1'b0; // Die still above hysteresis
  logic        pl      = 1'b0; // Left PWM sign
  logic        pr      = 1'b0; // Right PWM sign
  logic [1:0]  rnd     = 2'h3; // Random PWM enables per channel
  logic        hw      = 1'b0; // Hardware mode select
  logic        pbp     = 1'b0; // Static bridge pin
  logic        fsp     = 1'b0; // Static frequency pin
  logic        sd_req  = 1'b1; // Bench shutdown command
  logic        loop_en = 1'b0; // Fault fed back to shutdown
  logic [3:0]  lag     = 4'h0; // Host reaction delay
  logic        sd_n, f_n, oe, play, pbm, fsel, irq;
  logic [7:0]  awaddr  = '0;
  logic [7:0]  araddr  = '0;
  logic [31:0] wdata   = '0;
  logic [31:0] rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        net;            // Fault net with its pull-up
  integer      seed    = 32'hc8ef;
  int          bad_count = 0;
  int          cmp_count = 0;

  assign net = oe ? 1'b0 : 1'b1; // Pull-up unless pulled low
  // Free-running clock
  always #20 mclk_i = ~mclk_i;
  // Random differential signs, balanced on average
  always @(posedge mclk_i) begin
    if (rnd[0]) pl <= 1'($random(seed));
    if (rnd[1]) pr <= 1'($random(seed));
  end

  amp_fault_ctrl #(.RECOVERY_CYC(REC), .DC_CYC(DCC)) i_dut (
    .mclk_i(mclk_i), .sys_rst_i(rst),
    .supply_overvoltage_i(err[0]), .supply_undervoltage_i(err[1]),
    .bad_ratio_i(err[2]), .bad_rate_i(err[3]), .clk_stopped_i(err[4]),
    .output_overcurrent_i(err[5]), .die_overtemp_i(err[6]),
    .overtemp_hysteresis_i(hyst), .pwm_diff_l_i(pl), .pwm_diff_r_i(pr),
    .amp_shutdown_n_i(sd_n), .hw_mode_i(hw),
    .parallel_bridge_pin_i(pbp), .freq_sel_pin_i(fsp),
    .amp_fault_n_i(net), .amp_fault_n_o(f_n), .amp_fault_n_oe_o(oe),
    .amp_play_o(play), .parallel_bridge_mode_o(pbm), .freq_sel_o(fsel),
    .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  fault_host_model i_host (
    .mclk_i(mclk_i), .sys_rst_i(rst), .fault_net_i(net),
    .loop_en_i(loop_en), .sd_req_i(sd_req), .lag_i(lag),
    .amp_shutdown_n_o(sd_n));

  // Status bit that an error cause should set
  function automatic int st_bit(input int k);
    if (k < 2) return k;
    if (k < 5) return amp_fault_pkg::ST_CLOCKING_ERROR;
    return (k == 5) ? amp_fault_pkg::ST_OCE : amp_fault_pkg::ST_OTE;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Print the verdict and stop
  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // A bounded wait ran out
  task automatic hang;
    bad_count++;
    $display("ERROR %0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic wait_oe(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && oe !== v; n++) @(posedge mclk_i);
    if (oe !== v) hang();
  endtask
  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 64) hang();
    r = bresp;
    bready <= 1'b0;
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 64) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Shutdown toggle through the pin or the control bit
  task automatic toggle(input logic by_reg);
    logic [1:0] r;
    if (by_reg) begin
      wr(A_CT, 32'h0000_0000, r);
      wr(A_CT, 32'h0000_0001, r);
    end else begin
      @(posedge mclk_i);
      sd_req <= 1'b0;
      tick(4);
      chk(play, 1'b0);
      sd_req <= 1'b1;
    end
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    tick(20);
    rst <= 1'b0;
    tick(10);
    chk(oe, 1'b0);
    chk(play, 1'b1);
    chk({pbm, fsel}, 2'h0);
    rd(A_MK, d, r);
    chk(d, 32'h0000_0000);
    rd(A_CT, d, r);
    chk(d[0], 1'b1);
    rd(8'h40, d, r);
    chk(r, amp_fault_pkg::RESP_SLVERR);
    wr(8'h40, ALL, r);
    chk(r, amp_fault_pkg::RESP_SLVERR);
    // Every error cause in turn
    for (k = 0; k < 7; k++) begin
      wr(A_ST, ALL, r);
      err[k] <= 1'b1;
      hyst   <= (k == 6);
      tick(6);
      chk(oe, k >= 2);
      chk(play, 1'b0);
      if (k >= 2) chk(f_n, 1'b0);
      rd(A_ST, d, r);
      chk(d[st_bit(k)], 1'b1);
      err[k] <= 1'b0;
      tick(6);
      chk(oe, k >= 5);
      chk(play, k < 5);
      if (k >= 5) begin
        toggle(k == 6);
        tick(REC + 10);
        chk(oe, k == 6);
        hyst <= 1'b0;
        toggle(1'b0);
        wait_oe(1'b0, 20);
        tick(3);
        chk(play, 1'b1);
      end
    end
    // Toggle while the error persists, then an early toggle
    err[5] <= 1'b1;
    wait_oe(1'b1, 10);
    toggle(1'b0);
    wr(A_ST, ALL, r);
    tick(REC + 10);
    rd(A_ST, d, r);
    chk(d[amp_fault_pkg::ST_OCE], 1'b1);
    chk(oe, 1'b1);
    err[5] <= 1'b0;
    toggle(1'b1);
    wait_oe(1'b0, REC + 20);
    err[5] <= 1'b1;
    tick(3);
    err[5] <= 1'b0;
    wait_oe(1'b1, 10);
    toggle(1'b0);
    tick(REC / 2);
    chk(oe, 1'b1);
    wait_oe(1'b0, REC);
    // DC detect: balanced noise, polarity flip, then steady offset
    rnd <= 2'h3;
    tick(900);
    chk(oe, 1'b0);
    rnd <= 2'h1;
    tick(1);
    pr <= 1'b1;
    tick(200);
    pr <= 1'b0;
    tick(DCC - 110);
    chk(oe, 1'b0);
    wait_oe(1'b1, 400);
    rd(A_ST, d, r);
    chk(d[amp_fault_pkg::ST_DCE], 1'b1);
    rnd <= 2'h3;
    tick(REC + 200); // Right channel needs two windows to lose its offset
    chk(oe, 1'b1);
    toggle(1'b1);
    wait_oe(1'b0, 20);
    // Interrupt: raise, clear while present, masked source
    wr(A_MK, 32'h1 << amp_fault_pkg::ST_UVE, r);
    err[1] <= 1'b1;
    tick(5);
    chk(irq, 1'b1);
    wr(A_ST, ALL, r);
    tick(2);
    chk(irq, 1'b1);
    err[1] <= 1'b0;
    tick(5);
    wr(A_ST, ALL, r);
    tick(2);
    chk(irq, 1'b0);
    err[0] <= 1'b1;
    tick(5);
    chk(irq, 1'b0);
    err[0] <= 1'b0;
    // Static pins in hardware mode
    for (k = 0; k < 4; k++) begin
      hw  <= 1'b1;
      pbp <= k[0];
      fsp <= k[1];
      tick(4);
      chk({pbm, fsel}, {k[0], k[1]});
    end
    // Fault looped back to shutdown through a slow host
    lag     <= 4'(3 + ($random(seed) & 7));
    loop_en <= 1'b1;
    err[5]  <= 1'b1;
    tick(3);
    err[5] <= 1'b0;
    wait_oe(1'b1, 10);
    wait_oe(1'b0, REC + 40);
    tick(20);
    chk(play, 1'b1);
    wrap_up();
  end
endmodule
